// ---- src/sdm_pkg.sv ----
// Package for the line-interface detect multiplex block: sizes, timing and reset values
package sdm_pkg;
    localparam int CHANNELS      = 4;
    localparam int PINS          = 5;
    localparam int FREQ_W        = 4;
    localparam int DET_PIN       = 0;
    localparam int CTL2_PIN      = 1;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int PULSE_W_PS    = 31250000;
    localparam int MASK_PS       = 15625000;
    localparam int PERIOD_PS     = 203125000;
    localparam int TIMER_W       = 16;
    // Least times round up, the period and width are exact multiples here
    localparam int PULSE_W_CYC = PULSE_W_PS / CLK_PERIOD_PS;
    localparam int MASK_CYC    = (MASK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PERIOD_CYC  = PERIOD_PS / CLK_PERIOD_PS;
    localparam logic [PINS-1:0]   LATCH_RST = 5'h00;
    localparam logic [FREQ_W-1:0] FREQ_RST  = 4'h0;
endpackage

// ---- src/sdm_sync2.sv ----
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module sdm_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] q_d;

    always_comb begin
        meta_d = ce ? d : meta_q;
        q_d    = ce ? meta_q : q;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end
endmodule

// ---- src/sdm_slic_io.sv ----
// Line-interface pin logic with clock source choice and detect multiplexing
`timescale 1ns/1ps
module sdm_slic_io #(
    parameter int PERIOD_CYCLES = sdm_pkg::PERIOD_CYC,
    parameter int PULSE_CYCLES  = sdm_pkg::PULSE_W_CYC,
    parameter int MASK_CYCLES   = sdm_pkg::MASK_CYC
) (
    input  wire logic                                          clk_sys,
    input  wire logic                                          nrst,
    input  wire logic                                          ce,
    input  wire logic [sdm_pkg::CHANNELS*sdm_pkg::PINS-1:0]    pin_dir,
    input  wire logic [sdm_pkg::CHANNELS-1:0]                  latch_wr,
    input  wire logic [sdm_pkg::PINS-1:0]                      latch_wdata,
    input  wire logic [sdm_pkg::CHANNELS-1:0]                  output_tristate_bit,
    input  wire logic [sdm_pkg::CHANNELS*sdm_pkg::PINS-1:0]    line_interface_pins_in,
    output logic      [sdm_pkg::CHANNELS*sdm_pkg::PINS-1:0]    line_interface_pins_out,
    output logic      [sdm_pkg::CHANNELS*sdm_pkg::PINS-1:0]    line_interface_pins_oe,
    output logic      [sdm_pkg::CHANNELS*sdm_pkg::PINS-1:0]    pin_rdata,
    input  wire logic                                          clock_source_select,
    input  wire logic [sdm_pkg::FREQ_W-1:0]                    master_freq_select,
    input  wire logic                                          multiplex_enable,
    input  wire logic                                          select_pulse_polarity,
    input  wire logic                                          pcm_clk,
    input  wire logic                                          shared_clock_select_pin_in,
    output logic                                               shared_clock_select_pin_out,
    output logic                                               shared_clock_select_pin_oe,
    output logic                                               master_clk_int,
    output logic      [sdm_pkg::FREQ_W-1:0]                    master_freq,
    output logic                                               detect_select_pulse,
    output logic      [sdm_pkg::CHANNELS-1:0]                  detect_input_primary,
    output logic      [sdm_pkg::CHANNELS-1:0]                  detect_input_secondary,
    output logic      [sdm_pkg::CHANNELS-1:0]                  realtime_status_a,
    output logic      [sdm_pkg::CHANNELS-1:0]                  realtime_status_b
);
    import sdm_pkg::*;

    localparam int NP = CHANNELS * PINS;
    localparam logic [TIMER_W-1:0] PERIOD_LAST = TIMER_W'(PERIOD_CYCLES - 1);
    localparam logic [TIMER_W-1:0] PULSE_END   = TIMER_W'(PULSE_CYCLES);
    localparam logic [TIMER_W-1:0] MASK_END    = TIMER_W'(MASK_CYCLES);
    localparam logic [TIMER_W-1:0] MASK2_END   = TIMER_W'(PULSE_CYCLES + MASK_CYCLES);

    typedef enum logic [1:0] {
        MX_OFF,
        MX_IDLE,
        MX_ACTIVE
    } sdm_mx_state_t;

    // Multiplex running: shared by the readback, status and select pin drive
    function automatic logic mx_running(sdm_mx_state_t s);
        return s != MX_OFF;
    endfunction

    // Pin and clock inputs pass two flops before use
    logic [NP-1:0] pins_s;
    logic          pcm_clk_s;
    logic          mclk_pin_s;

    sdm_sync2 #(.WIDTH(NP)) u_sync_pins (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .d       (line_interface_pins_in),
        .q       (pins_s)
    );

    sdm_sync2 #(.WIDTH(2)) u_sync_clk (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .d       ({pcm_clk, shared_clock_select_pin_in}),
        .q       ({pcm_clk_s, mclk_pin_s})
    );

    // Output latches and configuration
    logic [NP-1:0]       latch_q;
    logic [NP-1:0]       latch_d;
    logic                mclk_q;
    logic                mclk_d;
    logic [FREQ_W-1:0]   freq_q;
    logic [FREQ_W-1:0]   freq_d;

    // Latch writes land on input pins as well, ready for a later direction change
    always_comb begin
        latch_d = latch_q;
        for (int c = 0; c < CHANNELS; c++) begin
            if (ce && latch_wr[c]) begin
                latch_d[c*PINS +: PINS] = latch_wdata;
            end
        end
        mclk_d = mclk_q;
        freq_d = freq_q;
        if (ce) begin
            mclk_d = clock_source_select ? pcm_clk_s : mclk_pin_s;
            freq_d = master_freq_select;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            latch_q <= {CHANNELS{LATCH_RST}};
            mclk_q  <= 1'b0;
            freq_q  <= FREQ_RST;
        end else begin
            latch_q <= latch_d;
            mclk_q  <= mclk_d;
            freq_q  <= freq_d;
        end
    end

    // Select pulse timer shared by all channels
    sdm_mx_state_t       mx_q;
    sdm_mx_state_t       mx_d;
    logic [TIMER_W-1:0]  tmr_q;
    logic [TIMER_W-1:0]  tmr_d;
    logic                mux_on;

    assign mux_on = clock_source_select && multiplex_enable;

    // The timer restarts at each pulse start, so the period is counted from there
    always_comb begin
        mx_d  = mx_q;
        tmr_d = tmr_q;
        if (ce) begin
            case (mx_q)
                MX_OFF: begin
                    tmr_d = '0;
                    if (mux_on) begin
                        mx_d = MX_ACTIVE;
                    end
                end
                MX_ACTIVE: begin
                    tmr_d = tmr_q + 1'b1;
                    if (!mux_on) begin
                        mx_d = MX_OFF;
                    end else if (tmr_q == PULSE_END - 1'b1) begin
                        mx_d = MX_IDLE;
                    end
                end
                MX_IDLE: begin
                    tmr_d = tmr_q + 1'b1;
                    if (!mux_on) begin
                        mx_d = MX_OFF;
                    end else if (tmr_q == PERIOD_LAST) begin
                        tmr_d = '0;
                        mx_d  = MX_ACTIVE;
                    end
                end
                default: begin
                    mx_d  = MX_OFF;
                    tmr_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mx_q  <= MX_OFF;
            tmr_q <= '0;
        end else begin
            mx_q  <= mx_d;
            tmr_q <= tmr_d;
        end
    end

    // Latch enables open after the mask that follows each pulse edge
    logic pulse_on;
    logic masked;
    logic en_primary;
    logic en_secondary;

    always_comb begin
        pulse_on = (mx_q == MX_ACTIVE);
        masked   = (mx_q != MX_OFF) &&
                   ((tmr_q < MASK_END) || (tmr_q >= PULSE_END && tmr_q < MASK2_END));
        if (mx_q == MX_OFF) begin
            en_primary   = 1'b1;
            en_secondary = 1'b0;
        end else begin
            en_primary   = !pulse_on && !masked;
            en_secondary = pulse_on && !masked;
        end
    end

    // Detect latches: follow the detect pin while enabled, hold otherwise
    logic [CHANNELS-1:0] prim_q;
    logic [CHANNELS-1:0] prim_d;
    logic [CHANNELS-1:0] sec_q;
    logic [CHANNELS-1:0] sec_d;

    always_comb begin
        prim_d = prim_q;
        sec_d  = sec_q;
        if (ce) begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (en_primary) begin
                    prim_d[c] = pins_s[c*PINS + DET_PIN];
                end
                if (en_secondary) begin
                    sec_d[c] = pins_s[c*PINS + DET_PIN];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prim_q <= '0;
            sec_q  <= '0;
        end else begin
            prim_q <= prim_d;
            sec_q  <= sec_d;
        end
    end

    // Registered pin drive, readback and status
    logic [NP-1:0]       pout_q;
    logic [NP-1:0]       pout_d;
    logic [NP-1:0]       poe_q;
    logic [NP-1:0]       poe_d;
    logic [NP-1:0]       rd_q;
    logic [NP-1:0]       rd_d;
    logic                sel_out_q;
    logic                sel_out_d;
    logic                sel_oe_q;
    logic                sel_oe_d;
    logic                pulse_q;
    logic                pulse_d;
    logic [CHANNELS-1:0] sta_q;
    logic [CHANNELS-1:0] sta_d;
    logic [CHANNELS-1:0] stb_q;
    logic [CHANNELS-1:0] stb_d;

    always_comb begin
        pout_d    = pout_q;
        poe_d     = poe_q;
        rd_d      = rd_q;
        sel_out_d = sel_out_q;
        sel_oe_d  = sel_oe_q;
        pulse_d   = pulse_q;
        sta_d     = sta_q;
        stb_d     = stb_q;
        if (ce) begin
            pout_d = latch_q;
            for (int c = 0; c < CHANNELS; c++) begin
                poe_d[c*PINS +: PINS] = pin_dir[c*PINS +: PINS] & {PINS{!output_tristate_bit[c]}};
                for (int p = 0; p < PINS; p++) begin
                    if (pin_dir[c*PINS + p]) begin
                        rd_d[c*PINS + p] = latch_q[c*PINS + p];
                    end else if (p == DET_PIN) begin
                        rd_d[c*PINS + p] = prim_q[c];
                    end else if (p == CTL2_PIN && mx_running(mx_q)) begin
                        rd_d[c*PINS + p] = sec_q[c];
                    end else begin
                        rd_d[c*PINS + p] = pins_s[c*PINS + p];
                    end
                end
                sta_d[c] = prim_q[c];
                stb_d[c] = mx_running(mx_q) ? sec_q[c] : pins_s[c*PINS + CTL2_PIN];
            end
            pulse_d   = pulse_on;
            sel_oe_d  = mx_running(mx_q);
            // An active-low pulse drives the pin high between pulses
            sel_out_d = mx_running(mx_q) && (pulse_on == select_pulse_polarity);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pout_q    <= '0;
            poe_q     <= '0;
            rd_q      <= '0;
            sel_out_q <= 1'b0;
            sel_oe_q  <= 1'b0;
            pulse_q   <= 1'b0;
            sta_q     <= '0;
            stb_q     <= '0;
        end else begin
            pout_q    <= pout_d;
            poe_q     <= poe_d;
            rd_q      <= rd_d;
            sel_out_q <= sel_out_d;
            sel_oe_q  <= sel_oe_d;
            pulse_q   <= pulse_d;
            sta_q     <= sta_d;
            stb_q     <= stb_d;
        end
    end

    assign line_interface_pins_out     = pout_q;
    assign line_interface_pins_oe      = poe_q;
    assign pin_rdata                   = rd_q;
    assign shared_clock_select_pin_out = sel_out_q;
    assign shared_clock_select_pin_oe  = sel_oe_q;
    assign master_clk_int              = mclk_q;
    assign master_freq                 = freq_q;
    assign detect_select_pulse         = pulse_q;
    assign detect_input_primary        = prim_q;
    assign detect_input_secondary      = sec_q;
    assign realtime_status_a           = sta_q;
    assign realtime_status_b           = stb_q;
endmodule

// ---- dv/sdm_slic_io_props.sv ----
// Checker for the line-interface detect multiplex block
`timescale 1ns/1ps
module sdm_slic_io_props #(
    parameter int PERIOD_CYCLES = 52,
    parameter int PULSE_CYCLES  = 8
) (
    input logic        clk_sys,
    input logic        nrst,
    input logic [19:0] pin_dir,
    input logic [3:0]  output_tristate_bit,
    input logic [19:0] line_interface_pins_out,
    input logic [19:0] line_interface_pins_oe,
    input logic [19:0] pin_rdata,
    input logic        clock_source_select,
    input logic        multiplex_enable,
    input logic        select_pulse_polarity,
    input logic        shared_clock_select_pin_out,
    input logic        shared_clock_select_pin_oe,
    input logic        detect_select_pulse,
    input logic [3:0]  detect_input_primary,
    input logic [3:0]  detect_input_secondary,
    input logic [3:0]  realtime_status_a,
    input logic [3:0]  realtime_status_b
);
    logic        mux_on, fell_q, fell_d, dsp_q;
    logic [19:0] drv;
    logic [15:0] low_q, low_d;
    assign mux_on = clock_source_select & multiplex_enable;
    assign drv = pin_dir & ~{{5{output_tristate_bit[3]}}, {5{output_tristate_bit[2]}},
                             {5{output_tristate_bit[1]}}, {5{output_tristate_bit[0]}}};
    // Low cycles since the last pulse, valid once a fall was seen while driving
    always_comb begin
        low_d  = detect_select_pulse ? 16'h0000 : low_q + 16'h0001;
        fell_d = shared_clock_select_pin_oe & (fell_q | (dsp_q & ~detect_select_pulse));
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            low_q  <= 16'h0000;
            fell_q <= 1'b0;
            dsp_q  <= 1'b0;
        end else begin
            low_q  <= low_d;
            fell_q <= fell_d;
            dsp_q  <= detect_select_pulse;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Eight matches PULSE_CYCLES of the bench
    sequence s_pulse;
        detect_select_pulse [*8] ##1 !detect_select_pulse;
    endsequence
    sequence s_hold2(x);
        $stable(x) ##1 $stable(x);
    endsequence
    chk_oe_follow: assert property ($past(nrst) |-> line_interface_pins_oe == $past(drv))
        else $error("pin enables do not follow direction and tristate");
    chk_rdata_out: assert property ($past(nrst) && $stable(pin_dir) |->
        ((pin_rdata ^ line_interface_pins_out) & pin_dir) == 20'h00000)
        else $error("output pin readback differs from latch");
    chk_pin_off: assert property (!mux_on [*3] |-> !shared_clock_select_pin_oe)
        else $error("select pin driven while multiplex off");
    chk_pin_on: assert property (mux_on [*3] |-> shared_clock_select_pin_oe)
        else $error("select pin not driven while multiplexing");
    chk_pin_level: assert property (shared_clock_select_pin_oe |-> shared_clock_select_pin_out ==
        (detect_select_pulse == $past(select_pulse_polarity)))
        else $error("select pin level wrong for polarity");
    chk_pulse_width: assert property ($rose(detect_select_pulse) |-> s_pulse)
        else $error("select pulse width wrong");
    chk_pulse_period: assert property ($rose(detect_select_pulse) && fell_q |->
        low_q == PERIOD_CYCLES - PULSE_CYCLES)
        else $error("select pulse period wrong");
    chk_prim_hold: assert property (detect_select_pulse |-> $stable(detect_input_primary))
        else $error("primary latch moved during pulse");
    chk_prim_mask: assert property ($fell(detect_select_pulse) |-> s_hold2(detect_input_primary))
        else $error("primary latch moved in mask");
    chk_sec_hold: assert property (!detect_select_pulse |-> $stable(detect_input_secondary))
        else $error("secondary latch moved outside pulse");
    chk_sec_mask: assert property ($rose(detect_select_pulse) |-> s_hold2(detect_input_secondary))
        else $error("secondary latch moved in mask");
    chk_status_bits: assert property ($past(mux_on, 2) && $past(mux_on) |->
        realtime_status_b == $past(detect_input_secondary) &&
        realtime_status_a == $past(detect_input_primary))
        else $error("status bits do not track detect latches");
endmodule

bind sdm_slic_io sdm_slic_io_props #(.PERIOD_CYCLES(PERIOD_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_props (.*);

// ---- dv/sdm_slic_model.sv ----
// Four line circuits sharing one select input, each with one detector output
`timescale 1ns/1ps
module sdm_slic_model #(
    parameter realtime SETTLE = 20.0
) (
    input  logic       sel_pin,
    input  logic       active_high,
    input  logic [3:0] loop_det,
    input  logic [3:0] gnd_key,
    output logic [3:0] det_out
);
    logic busy = 1'b0;
    // Detector output is wrong for a while after each select change
    always @(sel_pin) begin
        busy = 1'b1;
        #SETTLE busy = 1'b0;
    end
    // One select line switches all four detectors
    assign det_out = ((sel_pin == active_high) ? gnd_key : loop_det) ^ {4{busy}};
endmodule

// ---- dv/sdm_slic_io_test.sv ----
// Self-checking bench for the line-interface detect multiplex block
`timescale 1ns/1ps
module sdm_slic_io_test;
    logic        clk_sys = 0, nrst = 0, ce = 1, pcm_clk = 0, mclk = 0;
    logic        clock_source_select = 0, multiplex_enable = 0, select_pulse_polarity = 1;
    logic        shared_clock_select_pin_in, shared_clock_select_pin_out, shared_clock_select_pin_oe;
    logic        master_clk_int, detect_select_pulse;
    logic [19:0] pin_dir = 0, ext = 0, line_interface_pins_in, line_interface_pins_out;
    logic [19:0] line_interface_pins_oe, pin_rdata;
    logic [4:0]  latch_wdata = 0;
    logic [3:0]  latch_wr = 0, output_tristate_bit = 0, master_freq_select = 0, master_freq;
    logic [3:0]  loop_v = 0, gk_v = 0, line_detector_output, detect_input_primary, detect_input_secondary;
    logic [3:0]  realtime_status_a, realtime_status_b;
    int          err_count = 0, n_tests = 0, hi, bad;

    sdm_slic_io #(.PERIOD_CYCLES(52), .PULSE_CYCLES(8), .MASK_CYCLES(4)) u_dut (.*);
    sdm_slic_model u_slic (.sel_pin(shared_clock_select_pin_in), .active_high(select_pulse_polarity),
                           .loop_det(loop_v), .gnd_key(gk_v), .det_out(line_detector_output));

    // Pin 0 of each channel carries its detector; select pin carries mclk when undriven
    assign shared_clock_select_pin_in = shared_clock_select_pin_oe ? shared_clock_select_pin_out : mclk;
    always_comb begin
        line_interface_pins_in = ext;
        for (int c = 0; c < 4; c++) line_interface_pins_in[c*5] = line_detector_output[c];
        line_interface_pins_in = (line_interface_pins_oe & line_interface_pins_out) |
                                 (~line_interface_pins_oe & line_interface_pins_in);
    end

    initial forever #12.5 clk_sys = ~clk_sys;

    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic chk(string what, logic [19:0] seen, logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_latch(int c, logic [4:0] v);
        latch_wr    = 4'h1 << c;
        latch_wdata = v;
        step(1);
        latch_wr = 4'h0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        wrap_up();
    end

    initial begin
        step(2);
        nrst = 1;
        step(1);
        wr_latch(2, 5'h1a);
        loop_v = 4'h4;
        ext[3] = 1'b1;
        pin_dir[14:10] = 5'h1e;
        step(4);
        chk("oe", line_interface_pins_oe, 20'h07800);
        chk("out", line_interface_pins_out[14:10], 5'h1a);
        chk("rdata", pin_rdata[14:10], 5'h1b);
        chk("rdata in", pin_rdata[4:0], 5'h08);
        output_tristate_bit = 4'h4;
        wr_latch(2, 5'h04);
        step(2);
        chk("oe tri", line_interface_pins_oe, 20'h00000);
        chk("out tri", line_interface_pins_out[14:10], 5'h04);
        chk("rdata tri", pin_rdata[14:10], 5'h05);
        ce = 0;
        wr_latch(0, 5'h1f);
        ce = 1;
        step(3);
        chk("ce hold", line_interface_pins_out[4:0], 5'h00);
        $display("test pins done");
        mclk = 1;
        step(4);
        chk("mclk pin", master_clk_int, 1'b1);
        multiplex_enable = 1;
        step(3);
        chk("no pcm src", shared_clock_select_pin_oe, 1'b0);
        multiplex_enable = 0;
        clock_source_select = 1;
        step(4);
        chk("mclk pcm", master_clk_int, 1'b0);
        pcm_clk = 1;
        step(4);
        chk("pcm level", master_clk_int, 1'b1);
        pcm_clk = 0;
        for (int f = 0; f < 16; f++) begin
            master_freq_select = f[3:0];
            step(2);
            chk("freq", master_freq, f[3:0]);
        end
        mclk = 0;
        $display("test clock done");
        for (int p = 0; p < 2; p++) begin
            select_pulse_polarity = p[0];
            loop_v = 4'h5;
            gk_v = 4'ha;
            multiplex_enable = 1;
            step(3);
            chk("sel oe", shared_clock_select_pin_oe, 1'b1);
            step(156);
            chk("prim", detect_input_primary, 4'h5);
            chk("sec", detect_input_secondary, 4'ha);
            chk("rt a", realtime_status_a, 4'h5);
            chk("rt b", realtime_status_b, 4'ha);
            chk("rd mux", pin_rdata[9:0], 10'h049);
            loop_v = 4'ha;
            gk_v = 4'h5;
            step(104);
            chk("prim sw", detect_input_primary, 4'ha);
            chk("sec sw", detect_input_secondary, 4'h5);
            hi = 0;
            bad = 0;
            repeat (520) begin
                step(1);
                if (detect_select_pulse === 1'b1) hi++;
                if (detect_select_pulse === 1'b1 && shared_clock_select_pin_out !== p[0]) bad++;
            end
            chk("hi cycles", 20'(hi), 20'h00050);
            chk("pin level", 20'(bad), 20'h00000);
            for (int i = 0; i < 60 && detect_select_pulse !== 1'b1; i++) step(1);
            for (int i = 0; i < 60 && detect_select_pulse !== 1'b0; i++) step(1);
            step(6);
            multiplex_enable = 0;
            step(3);
            chk("sel off", shared_clock_select_pin_oe, 1'b0);
            loop_v = 4'h3;
            gk_v = 4'hc;
            step(6);
            chk("prim off", detect_input_primary, p ? 4'h3 : 4'hc);
            chk("sec off", detect_input_secondary, 4'h5);
            chk("rt b off", realtime_status_b, 4'h0);
        end
        $display("test multiplex done");
        wrap_up();
    end
endmodule
